// >>> rtl/tlbd_pkg.sv
// Purpose: shared constants, register coordinates and carriers of the tlb debug block
// Assumes: all registers live under primary_coproc_reg c15; bus address = coordinate index * 4
// Notes:   coordinate index is {opcode1[2:0], secondary_coproc_reg[3:0], opcode2[2:0]}
package tlbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int XLEN   = 32;         // data word of the bus and every register
  localparam int ADR_W  = 12;         // byte address width of the register window
  localparam int CTRL_W = 8;          // implemented bits of the debug control word

  // build a coordinate index from opcode1, secondary register and opcode2
  function automatic logic [9:0] tlbd_cp_idx(input logic [2:0] op1, input logic [3:0] secondary_coproc_reg,
                                             input logic [2:0] op2);
    return {op1, secondary_coproc_reg, op2};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register coordinates (word index)
  localparam logic [9:0] OFF_D_UIDX     = tlbd_cp_idx(3'h5, 4'h4, 3'h0);
  localparam logic [9:0] OFF_I_UIDX     = tlbd_cp_idx(3'h5, 4'h4, 3'h1);
  localparam logic [9:0] OFF_MAIN_ENTRY = tlbd_cp_idx(3'h5, 4'h4, 3'h4);
  localparam logic [9:0] OFF_MAIN_IDX   = tlbd_cp_idx(3'h5, 4'h4, 3'h5);
  localparam logic [9:0] OFF_U_VA_D     = tlbd_cp_idx(3'h5, 4'h5, 3'h0);
  localparam logic [9:0] OFF_U_PA_D     = tlbd_cp_idx(3'h5, 4'h6, 3'h0);
  localparam logic [9:0] OFF_U_ATTR_D   = tlbd_cp_idx(3'h5, 4'h7, 3'h0);
  localparam logic [9:0] OFF_M_VA       = tlbd_cp_idx(3'h5, 4'h5, 3'h2);
  localparam logic [9:0] OFF_M_PA       = tlbd_cp_idx(3'h5, 4'h6, 3'h2);
  localparam logic [9:0] OFF_M_ATTR     = tlbd_cp_idx(3'h5, 4'h7, 3'h2);
  localparam logic [9:0] OFF_CTRL       = tlbd_cp_idx(3'h7, 4'h1, 3'h0);

  ////////////////////////////////////////////////////////////////////////////
  // control word layout: base + side (side 0 = data, 1 = instruction)
  localparam int MICRO_LOAD_BASE  = 0;
  localparam int MICRO_MATCH_BASE = 2;
  localparam int MAIN_LOAD_BASE   = 4;
  localparam int MAIN_MATCH_BASE  = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;  // everything enabled after reset

  // entry va word: page number above VPN_LSB, valid flag at VALID_BIT
  localparam int VPN_LSB   = 12;
  localparam int VALID_BIT = 9;
  localparam int SIDE_D    = 0;
  localparam int SIDE_I    = 1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    SRC_NONE  = 2'b00,
    SRC_MICRO = 2'b01,
    SRC_MAIN  = 2'b10,
    SRC_WALK  = 2'b11
  } tlbd_src_e;

  typedef struct packed {
    logic [XLEN-1:0] va;    // page number + valid flag
    logic [XLEN-1:0] pa;    // physical word
    logic [XLEN-1:0] attr;  // attribute word
  } tlbd_entry_s;

  typedef struct packed {
    logic            valid; // lookup request this cycle
    logic [XLEN-1:0] va;
  } tlbd_req_s;

  typedef struct packed {
    logic            valid; // answer to last cycle's lookup
    tlbd_src_e       src;   // who served it; walk = miss in both levels
    logic [XLEN-1:0] pa;
    logic [XLEN-1:0] attr;
  } tlbd_resp_s;

  typedef struct packed {
    logic        valid;     // walker result pulse
    logic        side;      // which side asked
    tlbd_entry_s entry;     // translation found by the walk
  } tlbd_walk_s;

endpackage

// >>> rtl/tlbd_top.sv
// Purpose: tlb debug control and entry access behind a classic wishbone slave
// Assumes: one page walker outside; lookups from data (side 0) and instruction (side 1)
// Notes:   user-mode or unmapped accesses end with err; every access answers in one cycle
//
// Contract
// - micro load off: serve from main, keep micro
// - main load off: walks never refill main
// - micro match off: every lookup misses micro
// - main match off: ignore main hits, walk
// - micro index registers, data and instruction
// - main entry operation at c4 opcode2 4
// - entry read/write copies main entry registers
// - read-only micro va, pa, attribute registers
// - read/write main va, pa, attribute registers
// - debug control register at opcode1 7, c1
// - control bits disable functions, reset zero
`timescale 1ns/1ps
module tlbd_top
  import tlbd_pkg::*;
#(
  parameter int MAIN_ENTRIES = 8,
  parameter int MIDX_W       = 3,
  parameter int U_ENTRIES    = 4,
  parameter int UIDX_W       = 2
)(
  // clock, reset, enable
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  // classic wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [XLEN-1:0]    wb_dat_i,
  output logic [XLEN-1:0]         wb_dat_o,
  output logic                    wb_ack_o,
  output logic                    wb_err_o,
  input  wire logic               priv_i,
  // lookups, index 0 data, 1 instruction
  input  wire tlbd_req_s [1:0]    lk_req_i,
  output tlbd_resp_s [1:0]        lk_resp_o,
  // page walker
  output tlbd_req_s [1:0]         walk_req_o,
  input  wire tlbd_walk_s         walk_rsp_i,
  // micro tlb flush requests
  input  wire logic [1:0]         uflush_i
);

  if ((1 << MIDX_W) != MAIN_ENTRIES || MIDX_W > XLEN || UIDX_W > XLEN)
  begin : g_bad_shape
    $error("tlbd_top: MAIN_ENTRIES must be 2**MIDX_W");
  end

  typedef struct packed {
    logic [CTRL_W-1:0]              ctrl;   // debug control word
    logic [1:0][UIDX_W-1:0]         uidx;   // micro index per side
    logic [MIDX_W-1:0]              midx;   // main index
    tlbd_entry_s                    mreg;   // main va/pa/attr registers
    tlbd_entry_s [MAIN_ENTRIES-1:0] mtlb;   // main tlb store
    logic [MIDX_W-1:0]              fptr;   // walk refill victim
    logic                           ack;
    logic                           err;
    logic [XLEN-1:0]                rdat;
    tlbd_resp_s [1:0]               resp;
    tlbd_req_s [1:0]                walk;
  } top_st_s;

  top_st_s                          st_r;     // state
  top_st_s                          st_nxt;   // next state
  logic [1:0]                       u_hit;    // raw micro hit
  tlbd_entry_s [1:0]                u_ent;    // micro hit entry
  tlbd_entry_s [1:0]                u_dbg;    // micro debug entry
  logic [1:0]                       u_fill;   // micro refill strobe
  logic [1:0]                       u_flush;  // gated flush
  tlbd_entry_s [1:0]                u_fent;   // micro refill entry
  logic [1:0][MAIN_ENTRIES-1:0]     m_match;  // main per-entry hit
  logic [9:0]                       a;        // coordinate index
  logic                             acc;      // new bus request

  assign a   = wb_adr_i[ADR_W-1:2];
  assign acc = wb_cyc_i && wb_stb_i && !st_r.ack && !st_r.err;

  ////////////////////////////////////////////////////////////////////////////
  // micro tlbs and main compare, one per side / entry
  for (genvar s = 0; s < 2; s++)
  begin : g_side
    tlbd_utlb #(
      .ENTRIES (U_ENTRIES),
      .IDX_W   (UIDX_W)
    ) u_utlb (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .ce_i         (ce_i),
      .va_i         (lk_req_i[s].va),
      .hit_o        (u_hit[s]),
      .hit_entry_o  (u_ent[s]),
      .fill_i       (u_fill[s]),
      .fill_entry_i (u_fent[s]),
      .flush_i      (u_flush[s]),
      .dbg_idx_i    (st_r.uidx[s]),
      .dbg_entry_o  (u_dbg[s])
    );
    for (genvar e = 0; e < MAIN_ENTRIES; e++)
    begin : g_ment
      assign m_match[s][e] = st_r.mtlb[e].va[VALID_BIT] &&
                             (st_r.mtlb[e].va[XLEN-1:VPN_LSB] == lk_req_i[s].va[XLEN-1:VPN_LSB]);
    end
  end

  // byte-lane merge of a write word
  function automatic logic [XLEN-1:0] merge(input logic [XLEN-1:0] old, input logic [XLEN-1:0] wd,
                                            input logic [3:0] sel);
    logic [XLEN-1:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state: bus decode, lookups, walk refill
  always_comb
  begin
    logic            ok;
    logic [XLEN-1:0] rd;
    logic [XLEN-1:0] w;
    logic            mh;
    tlbd_entry_s     me;
    logic [MIDX_W-1:0] wi;
    ok      = 1'b1;
    rd      = '0;
    w       = '0;
    mh      = 1'b0;
    me      = '0;
    wi      = '0;
    st_nxt  = st_r;
    u_fill  = '0;
    u_fent  = '0;
    u_flush = '0;
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    // register access; user mode is refused with err
    if (acc)
    begin
      if (!priv_i)
        ok = 1'b0;
      else if (a == OFF_CTRL)
      begin
        w  = merge({{(XLEN-CTRL_W){1'b0}}, st_r.ctrl}, wb_dat_i, wb_sel_i);
        rd = {{(XLEN-CTRL_W){1'b0}}, st_r.ctrl};
        if (wb_we_i)
          st_nxt.ctrl = w[CTRL_W-1:0];
      end
      else if (a[9:1] == OFF_D_UIDX[9:1])
      begin
        rd = XLEN'(st_r.uidx[a[0]]);
        w  = merge(rd, wb_dat_i, wb_sel_i);
        if (wb_we_i)
          st_nxt.uidx[a[0]] = w[UIDX_W-1:0];
      end
      // main entry operation, data is the index
      else if (a == OFF_MAIN_ENTRY)
      begin
        rd = XLEN'(st_r.midx);
        wi = wb_dat_i[MIDX_W-1:0];
        // write copies registers in, read copies entry out
        if (wb_we_i)
        begin
          st_nxt.midx     = wi;
          st_nxt.mtlb[wi] = st_r.mreg;
        end
        else
          st_nxt.mreg = st_r.mtlb[st_r.midx];
      end
      // index alone, without touching any entry
      else if (a == OFF_MAIN_IDX)
      begin
        rd = XLEN'(st_r.midx);
        if (wb_we_i)
          st_nxt.midx = wb_dat_i[MIDX_W-1:0];
      end
      else if (a[9:1] == OFF_U_VA_D[9:1] || a[9:1] == OFF_U_PA_D[9:1] || a[9:1] == OFF_U_ATTR_D[9:1])
      begin
        ok = !wb_we_i;
        rd = (a[9:1] == OFF_U_VA_D[9:1]) ? u_dbg[a[0]].va :
             (a[9:1] == OFF_U_PA_D[9:1]) ? u_dbg[a[0]].pa : u_dbg[a[0]].attr;
      end
      else if (a == OFF_M_VA)
      begin
        rd = st_r.mreg.va;
        if (wb_we_i)
          st_nxt.mreg.va = merge(rd, wb_dat_i, wb_sel_i);
      end
      else if (a == OFF_M_PA)
      begin
        rd = st_r.mreg.pa;
        if (wb_we_i)
          st_nxt.mreg.pa = merge(rd, wb_dat_i, wb_sel_i);
      end
      else if (a == OFF_M_ATTR)
      begin
        rd = st_r.mreg.attr;
        if (wb_we_i)
          st_nxt.mreg.attr = merge(rd, wb_dat_i, wb_sel_i);
      end
      else
        ok = 1'b0;   // unmapped
      st_nxt.ack  = ok;
      st_nxt.err  = !ok;
      st_nxt.rdat = (ok && !wb_we_i) ? rd : '0;
    end
    // lookups per side
    for (int s = 0; s < 2; s++)
    begin
      mh = 1'b0;
      me = '0;
      for (int e = MAIN_ENTRIES - 1; e >= 0; e--)
      begin
        if (m_match[s][e])
        begin
          mh = 1'b1;
          me = st_r.mtlb[e];
        end
      end
      // main hits ignored while main match is off
      mh = mh && !st_r.ctrl[MAIN_MATCH_BASE + s];
      // flush held off together with load
      u_flush[s]          = uflush_i[s] && !st_r.ctrl[MICRO_LOAD_BASE + s];
      st_nxt.resp[s]      = '0;
      st_nxt.walk[s]      = '0;
      st_nxt.resp[s].valid = lk_req_i[s].valid;
      if (!lk_req_i[s].valid)
        st_nxt.resp[s].src = SRC_NONE;
      // micro hits ignored while micro match is off
      else if (u_hit[s] && !st_r.ctrl[MICRO_MATCH_BASE + s])
      begin
        st_nxt.resp[s].src  = SRC_MICRO;
        st_nxt.resp[s].pa   = u_ent[s].pa;
        st_nxt.resp[s].attr = u_ent[s].attr;
      end
      else if (mh)
      begin
        st_nxt.resp[s].src  = SRC_MAIN;
        st_nxt.resp[s].pa   = me.pa;
        st_nxt.resp[s].attr = me.attr;
        // refill micro only while its load is on
        u_fill[s] = !st_r.ctrl[MICRO_LOAD_BASE + s];
        u_fent[s] = me;
      end
      else
      begin
        st_nxt.resp[s].src = SRC_WALK;
        st_nxt.walk[s]     = lk_req_i[s];
      end
    end
    // walk result enters main only while main load is on
    if (walk_rsp_i.valid && !st_r.ctrl[MAIN_LOAD_BASE + 32'(walk_rsp_i.side)])
    begin
      st_nxt.mtlb[st_r.fptr] = walk_rsp_i.entry;
      st_nxt.fptr            = st_r.fptr + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; clock enable low freezes everything except the synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r      <= '0;
      // every disable bit clear after reset
      st_r.ctrl <= CTRL_RST;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o   = st_r.rdat;
  assign wb_ack_o   = st_r.ack;
  assign wb_err_o   = st_r.err;
  assign lk_resp_o  = st_r.resp;
  assign walk_req_o = st_r.walk;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_ctrl_reset_zero: assert property (@(posedge clk_i) rst_i |=> st_r.ctrl == CTRL_RST)
    else $error("control word not zero after reset");
  a_ctrl_write_value: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && priv_i && wb_we_i && a == OFF_CTRL && wb_sel_i == 4'hf)
    |=> st_r.ctrl == $past(wb_dat_i[CTRL_W-1:0]) && wb_ack_o)
    else $error("control write lost");
  a_umatch_off_miss: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && lk_req_i[0].valid && st_r.ctrl[MICRO_MATCH_BASE]) |=> lk_resp_o[0].src != SRC_MICRO)
    else $error("data micro hit while match off");
  a_mmatch_off_walk: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && lk_req_i[1].valid && st_r.ctrl[MAIN_MATCH_BASE + 1]) |=> lk_resp_o[1].src != SRC_MAIN)
    else $error("instruction main hit while match off");
  a_uload_off_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    st_r.ctrl[MICRO_LOAD_BASE] |=> $stable(g_side[0].u_utlb.st_r.ent))
    else $error("micro changed while load off");
  a_mload_off_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && walk_rsp_i.valid && st_r.ctrl[MAIN_LOAD_BASE + 32'(walk_rsp_i.side)])
    |=> $stable(st_r.fptr))
    else $error("main refilled while load off");
  a_entry_write_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && priv_i && wb_we_i && a == OFF_MAIN_ENTRY && !walk_rsp_i.valid)
    |=> st_r.mtlb[st_r.midx] == $past(st_r.mreg) && st_r.midx == $past(wb_dat_i[MIDX_W-1:0]))
    else $error("main entry write wrong");
  a_entry_read_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && priv_i && !wb_we_i && a == OFF_MAIN_ENTRY)
    |=> st_r.mreg == $past(st_r.mtlb[st_r.midx]) && wb_dat_o == XLEN'($past(st_r.midx)))
    else $error("main entry read wrong");
  a_uview_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && priv_i && wb_we_i && a[9:1] == OFF_U_PA_D[9:1]) |=> wb_err_o && !wb_ack_o)
    else $error("micro view write accepted");
  a_uidx_write_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && priv_i && wb_we_i && a == OFF_I_UIDX && wb_sel_i == 4'hf)
    |=> st_r.uidx[SIDE_I] == $past(wb_dat_i[UIDX_W-1:0]) ##1 (!ce_i || !wb_ack_o))
    else $error("instruction micro index wrong");
  a_main_rw_va: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && acc && priv_i && wb_we_i && a == OFF_M_VA && wb_sel_i == 4'hf)
    |=> st_r.mreg.va == $past(wb_dat_i))
    else $error("main va register write lost");

endmodule

// >>> rtl/tlbd_utlb.sv
// Purpose: one micro tlb: fully associative store, lookup, round-robin refill, debug read port
// Assumes: caller gates fill and flush with the debug control bits
// Notes:   lookup is combinational; state updates only while ce_i is high, except that reset clears it regardless
`timescale 1ns/1ps
module tlbd_utlb
  import tlbd_pkg::*;
#(
  parameter int ENTRIES = 4,
  parameter int IDX_W   = 2
)(
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // lookup
  input  wire logic [XLEN-1:0]   va_i,
  output logic                   hit_o,
  output tlbd_entry_s            hit_entry_o,
  // refill and flush
  input  wire logic              fill_i,
  input  wire tlbd_entry_s       fill_entry_i,
  input  wire logic              flush_i,
  // debug read
  input  wire logic [IDX_W-1:0]  dbg_idx_i,
  output tlbd_entry_s            dbg_entry_o
);

  // refuse shapes the pointer cannot serve
  if (ENTRIES < 2 || (1 << IDX_W) != ENTRIES)
  begin : g_bad_shape
    $error("tlbd_utlb: ENTRIES must be 2**IDX_W");
  end

  typedef struct packed {
    tlbd_entry_s [ENTRIES-1:0] ent;  // stored translations
    logic [IDX_W-1:0]          ptr;  // next victim
  } utlb_st_s;

  utlb_st_s               st_r;      // state
  utlb_st_s               st_nxt;    // next state
  logic [ENTRIES-1:0]     match;     // per-entry hit

  ////////////////////////////////////////////////////////////////////////////
  // per-entry compare of page number and valid flag
  for (genvar e = 0; e < ENTRIES; e++)
  begin : g_match
    assign match[e] = st_r.ent[e].va[VALID_BIT] &&
                      (st_r.ent[e].va[XLEN-1:VPN_LSB] == va_i[XLEN-1:VPN_LSB]);
  end

  // first matching entry wins; refill can duplicate a held page when the caller ignores micro hits
  always_comb
  begin
    hit_o       = 1'b0;
    hit_entry_o = '0;
    for (int e = ENTRIES - 1; e >= 0; e--)
    begin
      if (match[e])
      begin
        hit_o       = 1'b1;
        hit_entry_o = st_r.ent[e];
      end
    end
  end

  // debug port shows the raw entry, valid or not
  assign dbg_entry_o = st_r.ent[dbg_idx_i];

  ////////////////////////////////////////////////////////////////////////////
  // next state: flush first so a refill in the same cycle survives
  always_comb
  begin
    st_nxt = st_r;
    if (flush_i)
    begin
      st_nxt.ent = '0;
    end
    if (fill_i)
    begin
      st_nxt.ent[st_r.ptr] = fill_entry_i;
      st_nxt.ptr           = st_r.ptr + 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// >>> testbench/tb.sv
// Purpose: self-checking bench of the tlb debug block
// Assumes: lookups use page-aligned addresses so returned pa words compare exactly
// Notes:   entry pages a and b are loaded by the bus, page c only by the walker
`timescale 1ns/1ps
module tb
  import tlbd_pkg::*;
();
  localparam logic [XLEN-1:0] VA_A = 32'h0001_2200, PA_A = 32'h00ab_c000, AT_A = 32'h0000_0055;
  localparam logic [XLEN-1:0] VA_B = 32'h0003_4200, PA_B = 32'h00de_f000, AT_B = 32'h0000_0066;
  localparam logic [XLEN-1:0] VA_C = 32'h0005_6000, PA_C = 32'h8005_6000, AT_C = 32'h0000_00c3;
  logic              clk_i  = 1'b0;   // 40 MHz core clock
  logic              rst_i  = 1'b1;   // synchronous reset
  logic              priv   = 1'b1;   // privileged access
  logic [1:0]        uflush = 2'b00;  // micro flush pulses
  logic [3:0]        bsel   = 4'hf;   // write byte enables
  tlbd_req_s [1:0]   lk_req = '0;     // lookups from the core
  tlbd_resp_s [1:0]  lk_resp;
  tlbd_req_s [1:0]   walk_req;
  tlbd_walk_s        walk_rsp;
  logic              cyc, stb, we, ack, err;
  logic [ADR_W-1:0]  adr;
  logic [3:0]        sel;
  logic [XLEN-1:0]   wdat, rdat;
  int                n_fail = 0, cmp_count = 0;

  always #12.5 clk_i = ~clk_i;

  tlbd_top i_tlbd_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .priv_i(priv), .lk_req_i(lk_req), .lk_resp_o(lk_resp), .walk_req_o(walk_req),
    .walk_rsp_i(walk_rsp), .uflush_i(uflush));
  tlbd_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack), .err_i(err),
    .walk_req_i(walk_req), .walk_rsp_o(walk_rsp));

  //////////////////////////////////////////////////////////////////////////////
  // reporting and comparison
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bad(input string m);
    n_fail++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic chk_word(input logic [XLEN-1:0] g, e);
    cmp_count++;
    if (g !== e) bad($sformatf("word %h, expected %h", g, e));
  endtask
  task automatic chk_src(input tlbd_src_e g, e);
    cmp_count++;
    if (g !== e) bad($sformatf("source %0d, expected %0d", g, e));
  endtask
  task automatic chk_flag(input logic g, e);
    cmp_count++;
    if (g !== e) bad($sformatf("flag %b, expected %b", g, e));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // bus access: err flag always judged, read data only when accepted
  task automatic acc(input int w, input logic [ADR_W-1:0] a, input logic [XLEN-1:0] wd, xd,
                     input int xe);
    logic [XLEN-1:0] d;
    logic            e, t;
    u_core.xfer(w[0], a, wd, bsel, d, e, t);
    if (t)
    begin
      bad("bus answer missing");
      complete_run();
    end
    chk_flag(e, xe[0]);
    if (!w && !xe) chk_word(d, xd);
  endtask
  // one lookup; page-aligned va, answer judged in the cycle it stands
  task automatic look(input int s, input logic [XLEN-1:0] va, input tlbd_src_e xs, input logic [XLEN-1:0] xp);
    @(posedge clk_i);
    lk_req[s] <= '{valid: 1'b1, va: {va[31:12], 12'h000}};
    @(posedge clk_i);
    lk_req[s] <= '{valid: 1'b0, va: ~va};
    #1;
    chk_src(lk_resp[s].src, xs);
    chk_flag(walk_req[s].valid, xs == SRC_WALK);
    chk_flag(lk_resp[s].valid, 1'b1);
    if (xs != SRC_WALK) chk_word(lk_resp[s].pa, xp);
    if (xs != SRC_WALK) chk_word(lk_resp[s].attr, va == VA_A ? AT_A : va == VA_B ? AT_B : AT_C);
    repeat (u_core.lat + 3) @(posedge clk_i);
  endtask
  task automatic flush_d();
    @(posedge clk_i);
    uflush[0] <= 1'b1;
    @(posedge clk_i);
    uflush[0] <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  // byte address = {opcode1, secondary register, opcode2} * 4
  task automatic s_ctrl();
    acc(0, 12'he20, 0, 0, 0);
    priv <= 1'b0;
    acc(0, 12'he20, 0, 0, 1);
    priv <= 1'b1;
    acc(0, 12'h7fc, 0, 0, 1);
    bsel = 4'h1;
    acc(1, 12'he20, 32'hffff_ffff, 0, 0);
    bsel = 4'h2;
    acc(1, 12'he20, 32'h0, 0, 0);
    bsel = 4'hf;
    acc(0, 12'he20, 0, 32'hff, 0);
    acc(1, 12'he20, 0, 0, 0);
  endtask
  task automatic s_main();
    acc(1, 12'haa8, VA_A, 0, 0);
    acc(1, 12'hac8, PA_A, 0, 0);
    acc(1, 12'hae8, AT_A, 0, 0);
    acc(1, 12'ha90, 3, 0, 0);
    acc(1, 12'haa8, VA_B, 0, 0);
    acc(1, 12'hac8, PA_B, 0, 0);
    acc(1, 12'hae8, AT_B, 0, 0);
    acc(1, 12'ha90, 4, 0, 0);
    acc(1, 12'ha94, 3, 0, 0);
    acc(0, 12'ha90, 0, 3, 0);
    acc(0, 12'haa8, 0, VA_A, 0);
    acc(0, 12'hac8, 0, PA_A, 0);
    acc(0, 12'hae8, 0, AT_A, 0);
  endtask
  task automatic s_micro();
    look(0, VA_A, SRC_MAIN, PA_A);
    look(0, VA_A, SRC_MICRO, PA_A);
    look(1, VA_B, SRC_MAIN, PA_B);
    acc(1, 12'ha80, 1, 0, 0);
    acc(0, 12'ha80, 0, 1, 0);
    acc(0, 12'haa0, 0, 0, 0);
    acc(1, 12'ha80, 0, 0, 0);
    acc(0, 12'ha80, 0, 0, 0);
    acc(0, 12'haa0, 0, VA_A, 0);
    acc(0, 12'hac0, 0, PA_A, 0);
    acc(0, 12'hae0, 0, AT_A, 0);
    acc(1, 12'haa0, 1, 0, 1);
    acc(1, 12'hac4, 1, 0, 1);
    acc(1, 12'ha84, 0, 0, 0);
    acc(0, 12'haa4, 0, VA_B, 0);
  endtask
  task automatic s_disable();
    acc(1, 12'he20, 32'h01, 0, 0);
    flush_d();
    look(0, VA_A, SRC_MICRO, PA_A);
    look(0, VA_B, SRC_MAIN, PA_B);
    look(0, VA_B, SRC_MAIN, PA_B);
    acc(1, 12'he20, 32'h05, 0, 0);
    look(0, VA_A, SRC_MAIN, PA_A);
    acc(1, 12'he20, 32'hff, 0, 0);
    u_core.lat = 3;
    look(0, VA_A, SRC_WALK, 0);
    look(1, VA_B, SRC_WALK, 0);
    look(0, VA_C, SRC_WALK, 0);
    acc(1, 12'he20, 32'h0f, 0, 0);
    u_core.lat = 0;
    look(0, VA_C, SRC_WALK, 0);
    look(1, VA_C, SRC_MAIN, PA_C);
    acc(1, 12'he20, 32'h00, 0, 0);
    flush_d();
    look(0, VA_A, SRC_MAIN, PA_A);
  endtask

  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    s_ctrl();
    s_main();
    s_micro();
    s_disable();
    complete_run();
  end
endmodule

// >>> testbench/tlbd_core_model.sv
// Purpose: core-side partner: classic wishbone master for coprocessor transfers and a page walker
// Assumes: the walker answers the latest walk request after lat idle cycles
// Notes:   released cyc, stb and we go low, address and data show their inverse; sel_o keeps its last value
`timescale 1ns/1ps
module tlbd_core_model
  import tlbd_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone master side
  output logic                  cyc_o,
  output logic                  stb_o,
  output logic                  we_o,
  output logic [ADR_W-1:0]      adr_o,
  output logic [3:0]            sel_o,
  output logic [XLEN-1:0]       dat_o,
  input  wire logic [XLEN-1:0]  dat_i,
  input  wire logic             ack_i,
  input  wire logic             err_i,
  // page walker side
  input  wire tlbd_req_s [1:0]  walk_req_i,
  output tlbd_walk_s            walk_rsp_o
);
  int          lat  = 0;    // walker delay, set by the bench
  int          cnt  = -1;   // countdown of a pending walk
  tlbd_walk_s  pend = '0;   // walk being served

  initial
  begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    walk_rsp_o = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // walker: one outstanding walk at a time, a later request replaces it
  always @(posedge clk_i)
  begin
    for (int s = 0; s < 2; s++)
      if (walk_req_i[s].valid)
      begin
        pend.valid = 1'b1;
        pend.side = s[0];
        pend.entry.va = {walk_req_i[s].va[31:12], 12'h200};
        pend.entry.pa = {walk_req_i[s].va[31:12] ^ 20'h80000, 12'h000};
        pend.entry.attr = 32'h0000_00c3;
        cnt = lat;
      end
    // one assignment per edge: the answer, or the inverse of the last word with valid low
    if (cnt == 0)
      walk_rsp_o <= pend;
    else
      walk_rsp_o <= '{valid: 1'b0, side: ~walk_rsp_o.side, entry: ~walk_rsp_o.entry};
    if (cnt >= 0)
      cnt--;
    if (rst_i)
      cnt = -1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one classic cycle; request held until ack or err is sampled high, or 20 edges pass without either
  task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [XLEN-1:0] wd,
                      input logic [3:0] s, output logic [XLEN-1:0] rd, output logic er, output logic tmo);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, wd};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(ack_i || err_i) && n < 20);
    tmo = !(ack_i || err_i);
    rd = dat_i;
    er = err_i;
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {3'b000, ~a, ~wd};
  endtask
endmodule
